// ---- rtl/cu_pkg.sv ----
// Types shared by the card UART status block.
`default_nettype none
package cu_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_FRAME} cu_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_PEND, TX_SEND} cu_tx_t;
  typedef struct packed {
    logic thermal; logic supply; logic short_b; logic short_a;
    logic aux; logic det_b; logic det_a; logic rst; logic io;
  } cu_pins_t;
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid;
    logic [31:0] wdata; logic [3:0] wstrb; logic bready;
    logic arvalid; logic [7:0] araddr; logic rready;
  } cu_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } cu_axi_rsp_t;
  typedef struct packed {
    cu_pins_t s1; cu_pins_t s2; cu_pins_t s3;
    cu_axi_rsp_t ax;
    logic aw_got; logic w_got; logic [5:0] widx;
    logic [31:0] wdata; logic [3:0] wstrb;
    logic [8:0] ctrl; logic [15:0] etu; logic [7:0] egt;
    logic [7:0] uart_event_flags; logic [6:0] hardware_fault_latches;
    logic [7:0][7:0] mem; logic [2:0] wp; logic [2:0] rp;
    logic [3:0] cnt;
    logic [13:0] qc; logic [5:0] fq;
    cu_rx_t rxs; cu_tx_t txs;
    logic [8:0] rxb; logic bad; logic [2:0] perr;
    logic [10:0] txf; logic [9:0] gq;
    logic io_lvl; logic io_oe;
    logic [8:0] ea_cnt; logic [5:0] ea_smp;
    logic sel_q; logic txm_q; logic irq_n;
  } cu_state_t;
endpackage : cu_pkg
`default_nettype wire

// ---- rtl/cu_regs.svh ----
// Register map, field positions, reset values and timing counts.
// Overview of operation
// - Data port at one address: read rx, write tx
// - Host sees direct convention; hardware translates inverse
// - Data read returns oldest FIFO character
// - Sync mode read bit 0 shows I/O line
// - Sync mode write drives only bit 0
// - Transmit starts at write or after guard time
// - No new character while one is still sending
// - Status read clears flags except TBE; interrupt follows quickly
// - Timeout terminal counts set flags and interrupt
// - Start bit in reset window sets early flag
// - Early detection samples every 46, last 32 blind
// - Parity flag after allowed count, T=1 immediately
// - Bad parity dropped under T=0, kept under T=1
// - Parity flag at 10.5 rx, 11.5 tx ETU
// - Full FIFO drops character, sets overrun flag
// - Line low at 10.25 ETU sets framing flag
// - Short latches set, clear on read unless persisting
// - Supply latch clears only outside alarm
// - Presence latches set on any pin change
// - Aux latch set on either edge, read clears
// - Thermal latch clears on read unless persisting
// - Good character resets the parity error counter
`ifndef CU_REGS_SVH
`define CU_REGS_SVH
// Register word indices; byte address is four times the index.
`define CU_IDX_DATA 6'h0d
`define CU_IDX_USR 6'h0e
`define CU_IDX_HSR 6'h0f
`define CU_IDX_CTRL 6'h10
`define CU_IDX_ETU 6'h11
`define CU_IDX_EGT 6'h12
// Control register fields.
`define CU_C_CHAR_CONVENTION_SEL 0
`define CU_C_T1 1
`define CU_C_SYNC 2
`define CU_C_SEL 3
`define CU_C_PEC 6:4
`define CU_C_FIFO 7
`define CU_C_TXM 8
// Event flag bit positions.
`define CU_U_TBE 0
`define CU_U_FER 1
`define CU_U_OVR 2
`define CU_U_PE 3
`define CU_U_EA 4
`define CU_U_TO 7:5
// Fault latch bit positions.
`define CU_H_PTL 0
`define CU_H_AUX 1
`define CU_H_PRA 2
`define CU_H_PRB 3
`define CU_H_SUP 4
`define CU_H_SHA 5
`define CU_H_SHB 6
// Reset values and bus response codes.
`define CU_ETU_RST 16'h0174
`define CU_HSR_RST 7'h10
`define CU_RESP_OK 2'h0
`define CU_RESP_ERR 2'h2
// Frame timing in quarter ETU steps counted from the start edge.
`define CU_Q_LAST_BIT 6'h28
`define CU_Q_FRAME_CHK 6'h29
`define CU_Q_FLAG 6'h2a
`define CU_Q_TX_PE 6'h2e
`define CU_Q_TX_DONE 6'h30
`define CU_Q_RETRY 6'h3c
// Early answer window in clock cycles.
`define CU_EA_LOW_START 9'h0c8
`define CU_EA_END 9'h170
`define CU_EA_BLIND 9'h020
`define CU_EA_SAMPLE 6'h2e
`endif

// ---- rtl/cu_top.sv ----
// Card character port, event flags and fault latches behind AXI4-Lite.
`include "cu_regs.svh"
`default_nettype none
module cu_top (
  input  wire logic           aclk,         // System clock, 10 MHz.
  input  wire logic           aresetn,      // Synchronous reset, low.
  input  wire cu_pkg::cu_axi_req_t axi_req, // AXI4-Lite master side.
  output var  cu_pkg::cu_axi_rsp_t axi_rsp, // AXI4-Lite slave side.
  input  wire cu_pkg::cu_pins_t    pins,    // Asynchronous pin levels.
  input  wire logic [2:0]     timeout_done, // Terminal count pulses.
  output logic                card_io_out,  // Card I/O drive value.
  output logic                card_io_oe,   // Card I/O drive enable.
  output logic                irq_n         // Interrupt, active low.
);
  import cu_pkg::*;

  cu_state_t s_r;
  cu_state_t s_nxt;

  // Bit order follows the convention; inverse sends the MSB first.
  function automatic logic [7:0] order(input logic [7:0] b,
                                       input logic inv);
    logic [7:0] r;
    r = b;
    if (inv) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = b[7 - i];
      end
    end
    return r;
  endfunction : order

  // True on the tick that brings the frame count to the given step.
  function automatic logic at(input logic tick, input logic [5:0] fq,
                              input logic [5:0] q);
    return tick && (fq == q - 6'h01);
  endfunction : at

  always_comb begin
    cu_state_t n;
    logic tick, inv, t1, sync, txm, full, wr_go, rd_go;
    logic [13:0] quarter;
    logic [3:0] depth;
    logic [7:0] uset, uclr;
    logic [6:0] hset, hclr;
    logic [3:0] perr_inc;
    logic perr_over;
    logic [3:0] bit_idx;
    logic [8:0] ea_hi;
    logic ea_win, pok, start_frame;
    n = s_r;
    // Every local gets a value first so no path can hold one over.
    quarter = 14'h0000;
    tick = 1'b0;
    wr_go = 1'b0;
    rd_go = 1'b0;
    ea_win = 1'b0;
    uset = 8'h00;
    uclr = 8'h00;
    hset = 7'h00;
    hclr = 7'h00;
    start_frame = 1'b0;
    inv = s_r.ctrl[`CU_C_CHAR_CONVENTION_SEL];
    t1 = s_r.ctrl[`CU_C_T1];
    sync = s_r.ctrl[`CU_C_SYNC];
    txm = s_r.ctrl[`CU_C_TXM];
    depth = s_r.ctrl[`CU_C_FIFO] ? 4'h8 : 4'h1;
    full = s_r.cnt >= depth;
    // One bit wider than the counter so a limit of seven can be passed.
    perr_inc = {1'b0, s_r.perr} + 4'h1;
    perr_over = perr_inc > {1'b0, s_r.ctrl[`CU_C_PEC]};
    bit_idx = 4'((s_r.fq + 6'h01) >> 2);
    ea_hi = `CU_EA_END - `CU_EA_BLIND;
    pok = ~^s_r.rxb;

    // Pins pass two flip-flops; the third stage only feeds edge checks.
    n.s1 = pins;
    n.s2 = s_r.s1;
    n.s3 = s_r.s2;

    // Quarter ETU timebase, restarted at each frame start.
    quarter = (s_r.etu[15:2] == 14'h0000) ? 14'h0001 : s_r.etu[15:2];
    tick = s_r.qc == 14'h0000;
    n.qc = tick ? quarter - 14'h0001 : s_r.qc - 14'h0001;
    if (tick && s_r.fq != 6'h3f) begin
      n.fq = s_r.fq + 6'h01;
    end
    if (tick && s_r.gq != 10'h000 && s_r.txs != TX_SEND) begin
      n.gq = s_r.gq - 10'h001;
    end

    // Write channel: address and data are taken in either order.
    if (s_r.ax.awready && axi_req.awvalid) begin
      n.ax.awready = 1'b0;
      n.aw_got = 1'b1;
      n.widx = axi_req.awaddr[7:2];
    end
    if (s_r.ax.wready && axi_req.wvalid) begin
      n.ax.wready = 1'b0;
      n.w_got = 1'b1;
      n.wdata = axi_req.wdata;
      n.wstrb = axi_req.wstrb;
    end
    wr_go = s_r.aw_got && s_r.w_got && !s_r.ax.bvalid;
    if (wr_go) begin
      n.ax.bvalid = 1'b1;
      n.ax.bresp = `CU_RESP_OK;
      unique case (s_r.widx)
        `CU_IDX_DATA: begin
          if (s_r.wstrb[0]) begin
            if (sync) begin
              n.io_lvl = s_r.wdata[0];
            end else if (txm && s_r.txs == TX_IDLE) begin
              // Build start, data and even parity as line levels.
              n.txf = {1'b1, (^s_r.wdata[7:0]) ^ inv,
                       order(s_r.wdata[7:0], inv) ^ {8{inv}},
                       1'b0};
              n.txs = TX_PEND;
              uclr[`CU_U_TBE] = 1'b1;
            end
            // A write during a send is dropped on purpose.
          end
        end
        `CU_IDX_CTRL: begin
          if (s_r.wstrb[0]) begin
            n.ctrl[7:0] = s_r.wdata[7:0];
          end
          if (s_r.wstrb[1]) begin
            n.ctrl[8] = s_r.wdata[8];
          end
        end
        `CU_IDX_ETU: begin
          if (s_r.wstrb[0]) begin
            n.etu[7:0] = s_r.wdata[7:0];
          end
          if (s_r.wstrb[1]) begin
            n.etu[15:8] = s_r.wdata[15:8];
          end
        end
        `CU_IDX_EGT: begin
          if (s_r.wstrb[0]) begin
            n.egt = s_r.wdata[7:0];
          end
        end
        `CU_IDX_USR, `CU_IDX_HSR: begin
        end
        default: begin
          n.ax.bresp = `CU_RESP_ERR;
        end
      endcase
    end
    if (s_r.ax.bvalid && axi_req.bready) begin
      n.ax.bvalid = 1'b0;
      n.ax.awready = 1'b1;
      n.ax.wready = 1'b1;
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
    end

    // Read channel: side effects happen on the address handshake.
    rd_go = s_r.ax.arready && axi_req.arvalid;
    if (rd_go) begin
      n.ax.arready = 1'b0;
      n.ax.rvalid = 1'b1;
      n.ax.rresp = `CU_RESP_OK;
      n.ax.rdata = 32'h0000_0000;
      unique case (axi_req.araddr[7:2])
        `CU_IDX_DATA: begin
          if (sync) begin
            n.ax.rdata[0] = s_r.s2.io;
          end else begin
            n.ax.rdata[7:0] = s_r.mem[s_r.rp];
            if (s_r.cnt != 4'h0) begin
              n.rp = s_r.rp + 3'h1;
              n.cnt = s_r.cnt - 4'h1;
            end
            if (!txm) begin
              uclr[`CU_U_TBE] = 1'b1;
            end
          end
        end
        `CU_IDX_USR: begin
          n.ax.rdata[7:0] = s_r.uart_event_flags;
          uclr[7:1] = 7'h7f;
        end
        `CU_IDX_HSR: begin
          n.ax.rdata[6:0] = s_r.hardware_fault_latches;
          hclr = 7'h7f;
        end
        `CU_IDX_CTRL: n.ax.rdata[8:0] = s_r.ctrl;
        `CU_IDX_ETU: n.ax.rdata[15:0] = s_r.etu;
        `CU_IDX_EGT: n.ax.rdata[7:0] = s_r.egt;
        default: n.ax.rresp = `CU_RESP_ERR;
      endcase
    end
    if (s_r.ax.rvalid && axi_req.rready) begin
      n.ax.rvalid = 1'b0;
      n.ax.arready = 1'b1;
    end

    // Transmitter.
    if (!sync && s_r.txs != TX_SEND) begin
      n.io_lvl = 1'b1;
    end
    unique case (s_r.txs)
      TX_IDLE: begin
      end
      TX_PEND: begin
        if (s_r.gq == 10'h000) begin
          n.txs = TX_SEND;
          start_frame = 1'b1;
        end
      end
      TX_SEND: begin
        n.io_lvl = (s_r.fq < `CU_Q_LAST_BIT) ? s_r.txf[s_r.fq[5:2]]
                                             : 1'b1;
        if (at(tick, s_r.fq, `CU_Q_FLAG)) begin
          n.bad = !s_r.s2.io && !t1;
        end
        if (at(tick, s_r.fq, `CU_Q_TX_PE) && s_r.bad) begin
          n.perr = perr_inc[2:0];
          if (perr_over) begin
            uset[`CU_U_PE] = 1'b1;
            n.perr = 3'h0;
            n.txs = TX_IDLE;
            n.gq = {s_r.egt, 2'b00};
          end
        end
        if (at(tick, s_r.fq, `CU_Q_TX_DONE) && !s_r.bad) begin
          n.txs = TX_IDLE;
          n.perr = 3'h0;
          n.gq = {s_r.egt, 2'b00};
          uset[`CU_U_TBE] = 1'b1;
        end
        if (at(tick, s_r.fq, `CU_Q_RETRY) && s_r.bad) begin
          start_frame = 1'b1;
        end
      end
      default: n.txs = TX_IDLE;
    endcase

    // Receiver samples each bit at its middle, in half duplex.
    unique case (s_r.rxs)
      RX_IDLE: begin
        if (!txm && !sync && s_r.txs == TX_IDLE && !s_r.s2.io) begin
          n.rxs = RX_FRAME;
          start_frame = 1'b1;
        end
      end
      RX_FRAME: begin
        if (tick && s_r.fq[1:0] == 2'b01 && bit_idx >= 4'h1 &&
            bit_idx <= 4'h9) begin
          n.rxb[bit_idx - 4'h1] = s_r.s2.io ^ inv;
        end
        if (at(tick, s_r.fq, `CU_Q_FRAME_CHK)) begin
          n.bad = !s_r.s2.io;
        end
        if (at(tick, s_r.fq, `CU_Q_FLAG)) begin
          n.rxs = RX_IDLE;
          uset[`CU_U_FER] = s_r.bad;
          if (!pok) begin
            if (t1) begin
              uset[`CU_U_PE] = 1'b1;
            end else begin
              n.perr = perr_inc[2:0];
              if (perr_over) begin
                uset[`CU_U_PE] = 1'b1;
                n.perr = 3'h0;
              end
            end
          end else begin
            n.perr = 3'h0;
          end
          if (pok || t1) begin
            if (full) begin
              uset[`CU_U_OVR] = 1'b1;
            end else begin
              n.mem[s_r.wp] = order(s_r.rxb[7:0], inv);
              n.wp = s_r.wp + 3'h1;
              n.cnt = n.cnt + 4'h1;
              if (n.cnt == depth) begin
                uset[`CU_U_TBE] = 1'b1;
              end
            end
          end
        end
      end
      default: n.rxs = RX_IDLE;
    endcase
    if (start_frame) begin
      n.qc = quarter - 14'h0001;
      n.fq = 6'h00;
      n.bad = 1'b0;
    end

    // Early answer watch counts cycles since the reset pin changed.
    if (s_r.s2.rst != s_r.s3.rst) begin
      n.ea_cnt = 9'h000;
      n.ea_smp = 6'h00;
    end else begin
      if (s_r.ea_cnt != `CU_EA_END) begin
        n.ea_cnt = s_r.ea_cnt + 9'h001;
      end
      n.ea_smp = (s_r.ea_smp == `CU_EA_SAMPLE - 6'h01) ? 6'h00
                                                      : s_r.ea_smp + 6'h01;
    end
    ea_win = s_r.s2.rst ? (s_r.ea_cnt < ea_hi)
                        : (s_r.ea_cnt >= `CU_EA_LOW_START &&
                           s_r.ea_cnt < ea_hi);
    if (ea_win && s_r.ea_smp == 6'h00 && !s_r.s2.io && !txm && !sync) begin
      uset[`CU_U_EA] = 1'b1;
    end
    n.sel_q = s_r.ctrl[`CU_C_SEL];
    if (n.sel_q != s_r.sel_q) begin
      uclr[`CU_U_EA] = 1'b1;
    end
    n.txm_q = txm;
    if (txm && !s_r.txm_q) begin
      uset[`CU_U_TBE] = 1'b1;
    end
    if (!txm && s_r.txm_q) begin
      uclr[`CU_U_TBE] = 1'b1;
    end
    uset[`CU_U_TO] = timeout_done;

    // Fault latches; an active condition outweighs a read clear.
    hset[`CU_H_SHA] = s_r.s2.short_a;
    hset[`CU_H_SHB] = s_r.s2.short_b;
    hset[`CU_H_SUP] = s_r.s2.supply;
    hset[`CU_H_PTL] = s_r.s2.thermal;
    hset[`CU_H_PRA] = s_r.s2.det_a ^ s_r.s3.det_a;
    hset[`CU_H_PRB] = s_r.s2.det_b ^ s_r.s3.det_b;
    hset[`CU_H_AUX] = s_r.s2.aux ^ s_r.s3.aux;

    // Set wins over clear so no event is lost on a read.
    n.uart_event_flags = (s_r.uart_event_flags & ~uclr) | uset;
    n.hardware_fault_latches = (s_r.hardware_fault_latches & ~hclr) | hset;
    n.io_oe = !n.io_lvl;
    n.irq_n = !(|n.uart_event_flags || |n.hardware_fault_latches);
    s_nxt = n;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.etu <= `CU_ETU_RST;
      s_r.hardware_fault_latches <= `CU_HSR_RST;
      // The card line idles high, so its stages reset high: low would
      // look like a start bit the moment reset lifts.
      s_r.s1.io <= 1'b1;
      s_r.s2.io <= 1'b1;
      s_r.s3.io <= 1'b1;
      s_r.ax.awready <= 1'b1;
      s_r.ax.wready <= 1'b1;
      s_r.ax.arready <= 1'b1;
      s_r.io_lvl <= 1'b1;
      s_r.rxb <= 9'h000;
      s_r.rxs <= RX_IDLE;
      s_r.txs <= TX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign axi_rsp = s_r.ax;
  assign card_io_out = s_r.io_lvl;
  assign card_io_oe = s_r.io_oe;
  assign irq_n = s_r.irq_n;
endmodule : cu_top
`default_nettype wire

// ---- testbench/cu_card_model.sv ----
// Card side of the character line: sends asynchronous characters.
`default_nettype none
module cu_card_model #(
  parameter int ETU = 16
) (
  input  wire logic aclk, // Clock.
  input  wire logic line, // Line level seen at the card.
  output var  logic lvl   // Card drive; 1 releases to the pull-up.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial lvl = 1'b1;
  // Flags: bit 0 bad parity, bit 1 inverse convention, bit 2 low stop.
  task automatic send(input logic [7:0] d, input logic [2:0] f);
    logic [9:0] s;
    int         i;
    s[0] = 1'b0;
    for (i = 0; i < 8; i++) begin
      s[i+1] = f[1] ? ~d[7-i] : d[i];
    end
    s[9] = (f[1] ? ~(^d) : (^d)) ^ f[0];
    @(posedge aclk);
    for (i = 0; i < 10; i++) begin
      lvl <= s[i];
      repeat (ETU) @(posedge aclk);
    end
    // A low stop covers the 10.25 ETU check but lifts before 10.5 ETU,
    // where the receiver would take a still-low line for a new start bit.
    lvl <= ~f[2];
    repeat (ETU / 2) @(posedge aclk);
    lvl <= 1'b1;
    repeat (3 * ETU) @(posedge aclk);
  endtask : send
  // Receives one direct-convention character, sampled mid-bit.
  task automatic take(output logic [7:0] d, output logic p);
    int i;
    do @(posedge aclk); while (line);
    repeat (ETU / 2) @(posedge aclk);
    for (i = 0; i < 8; i++) begin
      repeat (ETU) @(posedge aclk);
      d[i] = line;
    end
    repeat (ETU) @(posedge aclk);
    p = line;
  endtask : take
endmodule : cu_card_model
`default_nettype wire

// ---- testbench/cu_top_assertions.sv ----
// Concurrent checks on the ports of the card UART register block.
`default_nettype none
module cu_top_assertions (
  input wire logic                aclk,         // Clock.
  input wire logic                aresetn,      // Reset, low.
  input wire cu_pkg::cu_axi_req_t axi_req,      // Bus requests.
  input wire cu_pkg::cu_axi_rsp_t axi_rsp,      // Bus answers.
  input wire cu_pkg::cu_pins_t    pins,         // Pin levels.
  input wire logic [2:0]          timeout_done, // Timeout pulses.
  input wire logic                card_io_out,  // I/O drive value.
  input wire logic                card_io_oe,   // I/O drive enable.
  input wire logic                irq_n         // Interrupt, low.
);
  timeunit 1ns;
  timeprecision 1ns;
  import cu_pkg::*;
  // Read address of the read in flight; stable until its answer is taken.
  logic [7:0] ar_q_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_q_r <= 8'h00;
    end else if (axi_req.arvalid && axi_rsp.arready) begin
      ar_q_r <= axi_req.araddr;
    end
  end
  a_open_drain:
    assert property (card_io_oe |-> !card_io_out)
    else $error("card line driven high");
  a_map_err:
    assert property (axi_rsp.rvalid && !(ar_q_r[7:2] inside {[6'h0d:6'h12]})
      |-> axi_rsp.rresp == 2'h2)
    else $error("unmapped read not refused");
  a_data_byte:
    assert property (axi_rsp.rvalid && ar_q_r == 8'h34
      |-> axi_rsp.rdata[31:8] == 24'h0)
    else $error("data read wider than a byte");
  a_hsr_top:
    assert property (axi_rsp.rvalid && ar_q_r == 8'h3c
      |-> axi_rsp.rdata[31:7] == 25'h0)
    else $error("fault register reserved bit set");
  a_tmo_irq:
    assert property (|timeout_done |-> ##[1:3] !irq_n)
    else $error("timeout gave no interrupt");
  a_heat_irq:
    assert property (pins.thermal |-> ##[1:6] !irq_n)
    else $error("thermal alarm gave no interrupt");
  a_short_irq:
    assert property (pins.short_a || pins.short_b |-> ##[1:6] !irq_n)
    else $error("short gave no interrupt");
  a_supply_irq:
    assert property (pins.supply |-> ##[1:6] !irq_n)
    else $error("supply alarm gave no interrupt");
endmodule : cu_top_assertions
`default_nettype wire

// ---- testbench/cu_top_tb_top.sv ----
// Self-checking bench for the card UART register block.
`default_nettype none
module cu_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cu_pkg::*;
  logic        aclk;
  logic        aresetn;
  cu_axi_req_t req;
  cu_axi_rsp_t rsp;
  cu_pins_t    pin_drv;
  cu_pins_t    pins;
  logic [2:0]  tmo;
  logic        io_out;
  logic        io_oe;
  logic        irq_n;
  logic        card_lvl;
  logic [31:0] rd_d;
  logic [1:0]  rd_r;
  logic [7:0]  tx_d;
  logic        tx_p;
  int          err_count;
  int          total_checks;
  int          k;
  int          pp[7] = '{8, 4, 2, 3, 7, 5, 6};
  // Open-drain line with pull-up: low if either side pulls it down.
  always_comb begin
    pins = pin_drv;
    pins.io = card_lvl & ~io_oe;
  end
  cu_top i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .pins(pins), .timeout_done(tmo),
    .card_io_out(io_out), .card_io_oe(io_oe), .irq_n(irq_n));
  cu_card_model #(.ETU(16)) i_card (.aclk(aclk), .line(pins.io),
    .lvl(card_lvl));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (rsp.awready) begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!rsp.bvalid);
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (!rsp.rvalid);
    rd_d = rsp.rdata;
    rd_r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_d, exp);
  endtask : chk_rd
  // Fault register reads are spaced by at least 2 us.
  task automatic hardware_fault_latches(input logic [6:0] exp);
    repeat (20) @(posedge aclk);
    chk_rd(8'h3c, {25'h0, exp});
  endtask : hardware_fault_latches
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_sim();
  end
  initial begin
    req = '0;
    pin_drv = '0;
    tmo = 3'h0;
    aresetn = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(8'h38, 32'h0);
    chk({31'h0, irq_n}, 32'h0);
    // A short ETU keeps every frame of the run brief.
    wr(8'h44, 32'h10);
    repeat (4000) @(posedge aclk);
    chk_rd(8'h38, 32'h0);
    rd(8'h34);
    hardware_fault_latches(7'h10);
    hardware_fault_latches(7'h00);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq_n}, 32'h1);
    rd(8'h50);
    chk({30'h0, rd_r}, 32'h2);
    for (k = 0; k < 7; k++) begin
      pin_drv[pp[k]] <= 1'b1;
      repeat (8) @(posedge aclk);
      chk({31'h0, irq_n}, 32'h0);
      hardware_fault_latches(7'h01 << k);
      hardware_fault_latches(7'h71 & (7'h01 << k));
      pin_drv[pp[k]] <= 1'b0;
      repeat (8) @(posedge aclk);
      hardware_fault_latches(7'h01 << k);
      hardware_fault_latches(7'h00);
    end
    for (k = 0; k < 3; k++) begin
      tmo <= 3'h1 << k;
      @(posedge aclk);
      tmo <= 3'h0;
      repeat (4) @(posedge aclk);
      chk_rd(8'h38, 32'h20 << k);
      chk_rd(8'h38, 32'h0);
    end
    wr(8'h40, 32'h80);
    i_card.send(8'ha5, 3'h0);
    i_card.send(8'h3c, 3'h0);
    chk_rd(8'h34, 32'ha5);
    chk_rd(8'h34, 32'h3c);
    pin_drv.rst <= 1'b1;
    i_card.send(8'h00, 3'h0);
    chk({31'h0, irq_n}, 32'h0);
    wr(8'h40, 32'h88);
    chk_rd(8'h38, 32'h0);
    chk_rd(8'h34, 32'h0);
    repeat (200) @(posedge aclk);
    wr(8'h40, 32'h81);
    i_card.send(8'h5a, 3'h2);
    chk_rd(8'h34, 32'h5a);
    wr(8'h40, 32'h80);
    i_card.send(8'h11, 3'h1);
    i_card.send(8'h22, 3'h0);
    chk_rd(8'h38, 32'h08);
    chk_rd(8'h34, 32'h22);
    wr(8'h40, 32'h82);
    i_card.send(8'h33, 3'h1);
    chk_rd(8'h38, 32'h08);
    chk_rd(8'h34, 32'h33);
    i_card.send(8'h44, 3'h4);
    chk_rd(8'h38, 32'h02);
    rd(8'h34);
    wr(8'h40, 32'h02);
    i_card.send(8'h55, 3'h0);
    i_card.send(8'h66, 3'h0);
    chk_rd(8'h38, 32'h05);
    chk_rd(8'h34, 32'h55);
    wr(8'h40, 32'h100);
    wr(8'h34, 32'ha5);
    fork
      i_card.take(tx_d, tx_p);
      begin
        repeat (40) @(posedge aclk);
        wr(8'h34, 32'h3c);
      end
    join
    chk({24'h0, tx_d}, 32'ha5);
    chk({31'h0, tx_p}, 32'h0);
    repeat (64) @(posedge aclk);
    chk_rd(8'h38, 32'h01);
    wr(8'h40, 32'h04);
    wr(8'h34, 32'hfe);
    repeat (4) @(posedge aclk);
    chk({30'h0, io_oe, io_out}, 32'h2);
    rd(8'h34);
    chk(rd_d & 32'h1, 32'h0);
    wr(8'h34, 32'h01);
    repeat (4) @(posedge aclk);
    chk({30'h0, io_oe, io_out}, 32'h1);
    rd(8'h34);
    chk(rd_d & 32'h1, 32'h1);
    end_sim();
  end
endmodule : cu_top_tb_top
bind cu_top cu_top_assertions i_chk (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .pins(pins),
  .timeout_done(timeout_done), .card_io_out(card_io_out),
  .card_io_oe(card_io_oe), .irq_n(irq_n));
`default_nettype wire
